// File: hdl/mtu_pkg.sv
// Package with register map, field layout and reset values of the modulo timer unit.
package mtu_pkg;
  localparam logic [3:0] MTU_OFF_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] MTU_OFF_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] MTU_OFF_CURRENT_COUNT  = 4'h8;
  localparam logic [3:0] MTU_OFF_WRAP_COMPARE   = 4'hC;
  localparam int MTU_BIT_OVERFLOW_FLAG   = 7;
  localparam int MTU_BIT_OVERFLOW_IRQ_EN = 6;
  localparam int MTU_BIT_COUNTER_RESET   = 5;
  localparam int MTU_BIT_COUNTER_STOP    = 4;
  localparam int MTU_POS_SOURCE_SELECT   = 4;
  localparam int MTU_POS_PRESCALE_SELECT = 0;
  localparam logic [7:0] MTU_RST_COUNT     = 8'h00;
  localparam logic [7:0] MTU_RST_COMPARE   = 8'h00;
  localparam logic [1:0] MTU_RST_SOURCE    = 2'h0;
  localparam logic [3:0] MTU_RST_PRESCALE  = 4'h0;
  localparam logic       MTU_RST_STOP      = 1'b1;
  localparam logic [3:0] MTU_PRESCALE_MAX  = 4'h8;
  localparam logic [1:0] MTU_SRC_BUS       = 2'h0;
  localparam logic [1:0] MTU_SRC_FIXED     = 2'h1;
  localparam logic [1:0] MTU_SRC_PIN_FALL  = 2'h2;
  localparam logic [1:0] MTU_SRC_PIN_RISE  = 2'h3;
  localparam logic [1:0] MTU_RESP_OKAY     = 2'h0;
  localparam logic [1:0] MTU_RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    MTU_ST_STOPPED = 2'b00,
    MTU_ST_FREE    = 2'b01,
    MTU_ST_MODULO  = 2'b11
  } mtu_mode_e;
endpackage

// File: hdl/mtu_edge_sync.sv
// Three-stage synchroniser with agreement-based edge detector for one external pin.
`timescale 1ns/1ps
module mtu_edge_sync
  import mtu_pkg::*;
(
  input  wire logic aclk,     // Bus clock.
  input  wire logic aresetn,  // Synchronous reset, active low.
  input  wire logic pin,      // Asynchronous pin input.
  output logic      rise,     // One-cycle pulse on a settled rising edge.
  output logic      fall      // One-cycle pulse on a settled falling edge.
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;
  logic changed;

  // The level only counts as changed once the second and third stages agree.
  assign agree   = (s2_q == s3_q);
  assign changed = agree && (s3_q != level_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      if (changed) begin
        level_q <= s3_q;
      end
      rise    <= changed && s3_q;
      fall    <= changed && !s3_q;
    end
  end
endmodule

// File: hdl/mtu_top.sv
// Modulo timer unit: AXI4-Lite register file, clock source select, prescaler and 8-bit modulo counter.
// Functional notes
// - Count register read-only, reset to zero.
// - Compare register read/write; zero means free-running.
// - Compare write clears count and overflow flag.
// - Modes stopped, free-running, modulo; stopped after reset.
// - Reset: stopped, zero, bus clock, divide one.
// - Four sources: bus, fixed, pin fall, rise.
// - Source change keeps the count running.
// - Prescaler divides by one to 256.
// - Prescale change keeps the count running.
// - Count up to compare value, then wrap.
// - Overflow flag sets on compare-to-zero wrap.
// - Flag clear: read while set, write zero.
// - Overflow between read and write cancels clear.
// - Counter reset bit also clears the flag.
// - Interrupt request equals flag and enable.
// - Source codes 00 bus to 11 rising.
// - Codes above 1000 divide by 256.
// - Reset bit reads zero; stop bit holds count.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module mtu_top
  import mtu_pkg::*;
#(
  parameter int CNT_W = 8  // Counter and compare width.
)(
  input  wire logic        aclk,                // Bus clock, 200 MHz.
  input  wire logic        aresetn,             // Synchronous reset, active low.
  input  wire logic [3:0]  s_axi_awaddr,        // Write address.
  input  wire logic        s_axi_awvalid,       // Write address valid.
  output logic             s_axi_awready,       // Write address ready.
  input  wire logic [31:0] s_axi_wdata,         // Write data.
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes.
  input  wire logic        s_axi_wvalid,        // Write data valid.
  output logic             s_axi_wready,        // Write data ready.
  output logic [1:0]       s_axi_bresp,         // Write response.
  output logic             s_axi_bvalid,        // Write response valid.
  input  wire logic        s_axi_bready,        // Write response ready.
  input  wire logic [3:0]  s_axi_araddr,        // Read address.
  input  wire logic        s_axi_arvalid,       // Read address valid.
  output logic             s_axi_arready,       // Read address ready.
  output logic [31:0]      s_axi_rdata,         // Read data.
  output logic [1:0]       s_axi_rresp,         // Read response.
  output logic             s_axi_rvalid,        // Read data valid.
  input  wire logic        s_axi_rready,        // Read data ready.
  input  wire logic        fixed_freq_clock,    // Fixed-frequency clock, asynchronous.
  input  wire logic        external_clock_pin,  // External clock pin, asynchronous.
  output logic             overflow_irq         // Overflow interrupt request, active high.
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] compare_q;
  logic             flag_q;
  logic             flag_d;
  logic             armed_q;
  logic             armed_d;
  logic             irq_en_q;
  logic             stop_q;
  logic [1:0]       source_q;
  logic [3:0]       prescale_q;
  logic [7:0]       div_q;
  logic [7:0]       div_d;
  mtu_mode_e        mode;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data are latched independently.
  logic        aw_have_q;
  logic [3:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_lane0;
  logic        wr_sc;
  logic        wr_clk;
  logic        wr_cmp;
  logic        wr_known;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb_q[0];
  assign wr_known      = (aw_addr_q == MTU_OFF_STATUS_CONTROL) || (aw_addr_q == MTU_OFF_CLOCK_CONFIG)
                      || (aw_addr_q == MTU_OFF_CURRENT_COUNT) || (aw_addr_q == MTU_OFF_WRAP_COMPARE);
  assign wr_sc         = wr_lane0 && (aw_addr_q == MTU_OFF_STATUS_CONTROL);
  assign wr_clk        = wr_lane0 && (aw_addr_q == MTU_OFF_CLOCK_CONFIG);
  assign wr_cmp        = wr_lane0 && (aw_addr_q == MTU_OFF_WRAP_COMPARE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MTU_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? MTU_RESP_OKAY : MTU_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.
  logic [3:0]  rd_addr;
  logic        rd_fire;
  logic [31:0] rd_word;
  logic        rd_known;
  logic        rd_sc;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = {s_axi_araddr[3:2], 2'b00};
  assign rd_sc         = rd_fire && (rd_addr == MTU_OFF_STATUS_CONTROL);
  assign rd_known      = (rd_addr == MTU_OFF_STATUS_CONTROL) || (rd_addr == MTU_OFF_CLOCK_CONFIG)
                      || (rd_addr == MTU_OFF_CURRENT_COUNT) || (rd_addr == MTU_OFF_WRAP_COMPARE);
  // The counter reset bit is write-only and always reads zero; low nibble unused.
  assign rd_word = (rd_addr == MTU_OFF_STATUS_CONTROL) ? {24'h0, flag_q, irq_en_q, 1'b0, stop_q, 4'h0}
                 : (rd_addr == MTU_OFF_CLOCK_CONFIG)   ? {24'h0, 2'b00, source_q, prescale_q}
                 : (rd_addr == MTU_OFF_CURRENT_COUNT)  ? {{(32-CNT_W){1'b0}}, count_q}
                 : (rd_addr == MTU_OFF_WRAP_COMPARE)   ? {{(32-CNT_W){1'b0}}, compare_q}
                 : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= MTU_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? MTU_RESP_OKAY : MTU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources: both asynchronous inputs become single-cycle enables.
  logic fixed_rise;
  logic pin_rise;
  logic pin_fall;
  logic src_tick;

  mtu_edge_sync u_fixed_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (fixed_freq_clock),
    .rise    (fixed_rise),
    .fall    ()
  );

  mtu_edge_sync u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (external_clock_pin),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // Selection is a plain mux, so a change neither clears the count nor the prescaler.
  assign src_tick = (source_q == MTU_SRC_BUS)      ? 1'b1
                  : (source_q == MTU_SRC_FIXED)    ? fixed_rise
                  : (source_q == MTU_SRC_PIN_FALL) ? pin_fall
                  : pin_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: a binary count of source ticks, held while stopped, tapped by the select code.
  logic [3:0] prescale_eff;
  logic [8:0] tap_mask;
  logic       count_en;

  assign prescale_eff = (prescale_q > MTU_PRESCALE_MAX) ? MTU_PRESCALE_MAX : prescale_q;
  // Divide by 2^n: the enable fires when the low n divider bits are all ones.
  // The divider is not cleared on a select change, so the first period at a new rate may be short.
  assign tap_mask = 9'((9'h001 << prescale_eff) - 9'h001);
  assign count_en = src_tick && !stop_q && ((div_q & tap_mask[7:0]) == tap_mask[7:0])
                 && (prescale_eff != MTU_PRESCALE_MAX || div_q == 8'hFF);
  assign div_d    = (src_tick && !stop_q) ? 8'(div_q + 8'h01) : div_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, overflow flag and its two-step clear.
  logic wrap;
  logic count_clear_wr;
  logic flag_wr_zero;
  logic compare_zero;

  assign compare_zero = (compare_q == CNT_W'(MTU_RST_COMPARE));
  // Gray order along the usual path: stopped, then free-running, then modulo once a compare is set.
  always_comb begin
    case ({stop_q, compare_zero})
      2'b01:   mode = MTU_ST_FREE;
      2'b00:   mode = MTU_ST_MODULO;
      default: mode = MTU_ST_STOPPED;
    endcase
  end
  // In free-running mode the compare of zero means wrap after the top value.
  assign wrap = count_en && (count_q == ((mode == MTU_ST_MODULO) ? compare_q : {CNT_W{1'b1}}));
  assign count_clear_wr = wr_sc && w_data_q[MTU_BIT_COUNTER_RESET];
  assign flag_wr_zero = wr_sc && !w_data_q[MTU_BIT_OVERFLOW_FLAG] && armed_q;

  always_comb begin
    count_d = count_q;
    if (wr_cmp || count_clear_wr) begin
      count_d = CNT_W'(MTU_RST_COUNT);
    end else if (wrap) begin
      count_d = CNT_W'(MTU_RST_COUNT);
    end else if (count_en) begin
      count_d = count_q + 1'b1;
    end
  end

  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    if (rd_sc && flag_q) begin
      armed_d = 1'b1;
    end
    if (flag_wr_zero || wr_cmp || count_clear_wr) begin
      flag_d  = 1'b0;
      armed_d = 1'b0;
    end
    // A new wrap wins over any clear and disarms a pending read-then-write.
    if (wrap) begin
      flag_d  = 1'b1;
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= CNT_W'(MTU_RST_COUNT);
      flag_q  <= 1'b0;
      armed_q <= 1'b0;
      div_q   <= 8'h00;
    end else begin
      count_q <= count_d;
      flag_q  <= flag_d;
      armed_q <= armed_d;
      div_q   <= div_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_q <= CNT_W'(MTU_RST_COMPARE);
    end else if (wr_cmp) begin
      compare_q <= w_data_q[CNT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 1'b0;
      stop_q   <= MTU_RST_STOP;
    end else if (wr_sc) begin
      irq_en_q <= w_data_q[MTU_BIT_OVERFLOW_IRQ_EN];
      stop_q   <= w_data_q[MTU_BIT_COUNTER_STOP];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_q   <= MTU_RST_SOURCE;
      prescale_q <= MTU_RST_PRESCALE;
    end else if (wr_clk) begin
      source_q   <= w_data_q[MTU_POS_SOURCE_SELECT +: 2];
      prescale_q <= w_data_q[MTU_POS_PRESCALE_SELECT +: 4];
    end
  end

  // Level request; software is expected to clear the flag before enabling.
  assign overflow_irq = flag_q && irq_en_q;
endmodule

// File: bench/mtu_checker.sv
// Concurrent checks on the bus and interrupt ports of the modulo timer unit.
`timescale 1ns/1ps
module mtu_checker
  import mtu_pkg::*;
(
  input wire logic        aclk,           // Bus clock.
  input wire logic        aresetn,        // Reset, active low.
  input wire logic        s_axi_awready,  // Write address ready.
  input wire logic [1:0]  s_axi_bresp,    // Write response.
  input wire logic        s_axi_bvalid,   // Write response valid.
  input wire logic        s_axi_bready,   // Write response ready.
  input wire logic [3:0]  s_axi_araddr,   // Read address.
  input wire logic        s_axi_arvalid,  // Read address valid.
  input wire logic        s_axi_arready,  // Read address ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic [1:0]  s_axi_rresp,    // Read response.
  input wire logic        s_axi_rvalid,   // Read data valid.
  input wire logic        s_axi_rready,   // Read data ready.
  input wire logic        overflow_irq    // Interrupt request.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // The read data must be judged by the address that was taken, not the one on the bus now.
  logic [3:0] ra_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken.");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped or changed before it was taken.");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("Write address accepted while a response is pending.");
  AST_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == MTU_RESP_OKAY)
    else $error("Write response is not okay.");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !overflow_irq)
    else $error("Outputs not idle after reset.");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Upper read data bits not zero.");
  AST_RRESP_OKAY: assert property (s_axi_rvalid |-> s_axi_rresp == MTU_RESP_OKAY)
    else $error("Read response is not okay.");
  AST_RESET_BIT_ZERO: assert property (s_axi_rvalid && ra_q == MTU_OFF_STATUS_CONTROL |->
    s_axi_rdata[MTU_BIT_COUNTER_RESET] == 1'h0 && s_axi_rdata[3:0] == 4'h0)
    else $error("Status read shows reset bit or unused bits set.");
  AST_IRQ_FALL: assert property ($fell(overflow_irq) |-> $rose(s_axi_bvalid))
    else $error("Interrupt dropped without a register write.");
endmodule

bind mtu_top mtu_checker mtu_checker_i (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready,
  .overflow_irq);

// File: bench/modulo_overflow_timer_test.sv
// Self-checking testbench for the modulo timer unit with an integer model of counter and flag.
`timescale 1ns/1ps
module modulo_overflow_timer_test;
  import mtu_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic        fx = 1'h0, pin = 1'h0, awr, wr, bv, arr, rv, irq;
  logic [3:0]  aw_a = 4'h0, ar_a = 4'h0, strb = 4'h0;
  logic [31:0] wd = 32'h0, rd, rdat;
  int          cnt, cmp, flag, armed, ien, stop, src, div_sel, p, n, mismatches = 0, n_checks = 0;

  mtu_top mtu_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ar_a), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .fixed_freq_clock(fx), .external_clock_pin(pin), .overflow_irq(irq));

  initial begin
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Ready is sampled on the falling edge, where it already holds the value the next rising edge sees.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    logic ha, hw, hb;
    @(posedge aclk);
    aw_a <= a;
    wd <= d;
    strb <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      @(posedge aclk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
      if (hb) break;
    end
    bready <= 1'h0;
    if (i == 64) begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic rd_reg(input logic [3:0] a);
    int i;
    logic ha, hb;
    @(posedge aclk);
    ar_a <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      ha = arv && arr;
      hb = rv;
      rd = rdat;
      @(posedge aclk);
      if (ha) arv <= 1'h0;
      if (hb) break;
    end
    rready <= 1'h0;
    if (i == 64) begin
      mismatches++;
      print_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic model_rst();
    {cnt, cmp, flag, armed, ien, src, div_sel, p} = '0;
    stop = 1;
  endtask

  task automatic st_wr(input logic [31:0] d);
    wr_reg(MTU_OFF_STATUS_CONTROL, d, 4'hF);
    if (!d[7] && armed) flag = 0;
    armed = 0;
    ien = d[6];
    stop = d[4];
    if (d[5]) {cnt, flag} = '0;
  endtask

  task automatic cm_wr(input logic [7:0] v);
    wr_reg(MTU_OFF_WRAP_COMPARE, {24'h0, v}, 4'hF);
    cmp = v;
    {cnt, flag} = '0;
  endtask

  // Reading the status arms the flag clear only while the flag is set.
  task automatic st_chk();
    rd_reg(MTU_OFF_STATUS_CONTROL);
    chk(rd, {24'h0, flag[0], ien[0], 1'h0, stop[0], 4'h0});
    armed = flag;
    rd_reg(MTU_OFF_CURRENT_COUNT);
    chk(rd, 32'(cnt));
    @(negedge aclk);
    chk({31'h0, irq}, 32'(flag && ien));
  endtask

  // Each pulse holds both levels for three cycles, so the synchroniser sees every edge.
  task automatic pulse(input int num, input logic f);
    repeat (num) begin
      @(posedge aclk);
      if (f) fx <= 1'h1;
      else pin <= 1'h1;
      repeat (3) @(posedge aclk);
      fx <= 1'h0;
      pin <= 1'h0;
      repeat (2) @(posedge aclk);
      if (!stop && (f ? src == 1 : src >= 2)) begin
        p = (p + 1) % 256;
        if (p % (1 << (div_sel > 8 ? 8 : div_sel)) == 0) begin
          if (cnt == (cmp == 0 ? 255 : cmp)) begin
            {cnt, armed} = '0;
            flag = 1;
          end
          else cnt++;
        end
      end
    end
    repeat (8) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(52919));
    model_rst();
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    st_chk();
    rd_reg(MTU_OFF_CLOCK_CONFIG);
    chk(rd, 32'h0);
    rd_reg(MTU_OFF_WRAP_COMPARE);
    chk(rd, 32'h0);
    wr_reg(MTU_OFF_CURRENT_COUNT, 32'h55, 4'hF);
    st_chk();
    cm_wr(8'($urandom_range(12, 3)));
    wr_reg(MTU_OFF_WRAP_COMPARE, 32'hAA, 4'hE);
    rd_reg(MTU_OFF_WRAP_COMPARE);
    chk(rd, 32'(cmp));
    for (src = 1; src < 4; src++) begin
      wr_reg(MTU_OFF_CLOCK_CONFIG, 32'(src << 4), 4'hF);
      st_wr(32'h0);
      pulse($urandom_range(20, 1), 1'h0);
      pulse($urandom_range(20, 1), 1'h1);
      st_chk();
    end
    pulse(cmp + 1, 1'h0);
    st_chk();
    pulse(cmp + 1, 1'h0);
    st_wr(32'h0);
    st_wr(32'h0);
    st_chk();
    st_wr(32'h0);
    st_wr(32'h40);
    pulse(cmp + 1, 1'h0);
    st_chk();
    st_wr(32'h60);
    st_chk();
    pulse(cmp + 1, 1'h0);
    cm_wr(8'($urandom_range(9, 4)));
    st_chk();
    st_wr(32'h50);
    pulse(5, 1'h0);
    st_chk();
    cm_wr(8'h0);
    st_wr(32'h40);
    pulse(300, 1'h0);
    st_chk();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    model_rst();
    st_chk();
    // Largest divisor first keeps each run on a whole period of the tap, so edge phase cannot matter.
    for (n = 15; n >= 0; n--) begin
      wr_reg(MTU_OFF_CLOCK_CONFIG, {26'h0, MTU_SRC_PIN_RISE, n[3:0]}, 4'hF);
      {src, div_sel} = {32'd3, n};
      rd_reg(MTU_OFF_CLOCK_CONFIG);
      chk(rd, {26'h0, MTU_SRC_PIN_RISE, n[3:0]});
      if (n == 15) st_wr(32'h0);
      pulse((1 << (n > 8 ? 8 : n)) * $urandom_range(2, 1), 1'h0);
      st_chk();
    end
    print_verdict();
  end
endmodule
